// ==== shared/mrp_pkg.sv ====
package mrp_pkg;

  // bus and port geometry
  localparam int ADDR_LOW_W  = 8;
  localparam int ADDR_HIGH_W = 3;
  localparam int ROM_ADDR_W  = ADDR_LOW_W + ADDR_HIGH_W;
  localparam int PORT_W      = 8;

  // positions of the latched low address bits that pick a port target
  localparam int SEL_PORT_BIT = 0;
  localparam int SEL_DIR_BIT  = 1;

  // target codes on the two latched low address bits
  localparam logic [1:0] SEL_FIRST_DATA  = 2'h0;
  localparam logic [1:0] SEL_SECOND_DATA = 2'h1;
  localparam logic [1:0] SEL_FIRST_DIR   = 2'h2;
  localparam logic [1:0] SEL_SECOND_DIR  = 2'h3;

  // reset values
  localparam logic [7:0] RST_ADDR_LOW   = 8'h00;
  localparam logic [2:0] RST_ADDR_HIGH  = 3'h0;
  localparam logic       RST_IO_SEL     = 1'h0;
  localparam logic       RST_CSL_N      = 1'h1;
  localparam logic       RST_CSH        = 1'h0;
  localparam logic [7:0] RST_BUS_DATA   = 8'h00;
  localparam logic [7:0] RST_PORT_DATA  = 8'h00;
  localparam logic [7:0] RST_PORT_DIR   = 8'h00;
  localparam logic [7:0] RST_PORT_OE_N  = 8'hFF;

  // where read data on the shared bus comes from
  typedef enum logic [1:0] {
    MRP_SRC_NONE,
    MRP_SRC_ROM,
    MRP_SRC_PORT
  } mrp_src_t;

endpackage : mrp_pkg

// ==== hdl/mrp_io_port.sv ====
// one parallel port: data latch, direction register, glitch-free commit
module mrp_io_port #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         wr_take,
  input  wire logic         wr_commit,
  input  wire logic         wr_is_dir,
  input  wire logic [W-1:0] wr_data,
  input  wire logic [W-1:0] pins_in,
  output logic      [W-1:0] pins_out,
  output logic      [W-1:0] pins_oe_n,
  output logic      [W-1:0] read_val
);

  logic [W-1:0] data_reg;
  logic [W-1:0] dir_reg;
  logic [W-1:0] oe_n_reg;
  logic [W-1:0] pend_reg;
  logic         pend_dir_reg;
  logic         pend_ok_reg;

  // while the write strobe is low the last bus value is only held pending
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pend_reg     <= W'(mrp_pkg::RST_PORT_DATA);
      pend_dir_reg <= 1'b0;
      pend_ok_reg  <= 1'b0;
    end else if (wr_take) begin
      pend_reg     <= wr_data;
      pend_dir_reg <= wr_is_dir;
      pend_ok_reg  <= 1'b1;
    end else if (wr_commit) begin
      pend_ok_reg  <= 1'b0;
    end
  end

  // pins only move once the strobe is back high, so they never glitch
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      data_reg <= W'(mrp_pkg::RST_PORT_DATA);
      dir_reg  <= W'(mrp_pkg::RST_PORT_DIR); // RL14
      oe_n_reg <= W'(mrp_pkg::RST_PORT_OE_N); // RL14
    end else if (wr_commit && pend_ok_reg) begin
      if (pend_dir_reg) begin
        dir_reg  <= pend_reg;
        oe_n_reg <= ~pend_reg;
      end else begin
        data_reg <= pend_reg; // RL15
      end
    end
  end

  assign pins_out  = data_reg;
  assign pins_oe_n = oe_n_reg;

  // output bits read back their latch, input bits read the pin
  assign read_val = (dir_reg & data_reg) | (~dir_reg & pins_in);

endmodule : mrp_io_port

// ==== hdl/mrp_host_port.sv ====
// What this block does
// RL1: bus, upper bits, space and chip selects flow into the latch while the strobe is high.
// RL2: the processor drives the low eight address bits on the shared lines during the strobe.
// RL3: an I/O access picks the first or second port from latched address bit zero.
// RL4: a low read or port-read strobe with active latched selects drives read data onto the bus.
// RL5: the three upper address bits only address the ROM array and never touch port accesses.
// RL6: the first select is active low, the second active high, both active when latched.
// RL7: with either select inactive the shared bus and the wait output stay released.
// RL8: a read strobe returns port data for a high latched space select, ROM data for a low one.
// RL9: the shared bus drivers are released whenever the read and port-read strobes are both high.
// RL10: a low port-write strobe with active latched selects writes the target the low bits pick.
// RL11: live selects and a high latch strobe pull the wait low; the processor clock frees it.
// RL12: once low the wait output stays low until the next rising edge of the processor clock.
// RL13: latched low bits 00, 01, 10, 11 pick first port, second port, first and second direction.
// RL14: reset clears both direction registers so every port line is an input.
// RL15: after a port write the pin levels only change once the port-write strobe returns high.
// RL16: latched values stay unchanged from the fall of the latch strobe until it next rises.
module mrp_host_port #(
  parameter int PORT_W = mrp_pkg::PORT_W
) (
  input  wire logic                           clk_sys,
  input  wire logic                           rst,
  input  wire logic                           ale,
  input  wire logic [mrp_pkg::ADDR_LOW_W-1:0] muxed_addr_data_in,
  output logic      [mrp_pkg::ADDR_LOW_W-1:0] muxed_addr_data_out,
  output logic                                muxed_addr_data_oe_n,
  input  wire logic [mrp_pkg::ADDR_HIGH_W-1:0] upper_rom_addr,
  input  wire logic                           io_mem_sel,
  input  wire logic                           program_or_chip_sel_n,
  input  wire logic                           chip_sel_high,
  input  wire logic                           read_strobe_n,
  input  wire logic                           port_read_strobe_n,
  input  wire logic                           port_write_strobe_n,
  input  wire logic                           cpu_clk,
  output logic                                wait_out,
  output logic                                wait_oe_n,
  output logic      [mrp_pkg::ROM_ADDR_W-1:0] rom_addr,
  input  wire logic [mrp_pkg::ADDR_LOW_W-1:0] rom_data,
  input  wire logic [PORT_W-1:0]              first_port_lines_in,
  output logic      [PORT_W-1:0]              first_port_lines_out,
  output logic      [PORT_W-1:0]              first_port_lines_oe_n,
  input  wire logic [PORT_W-1:0]              second_port_lines_in,
  output logic      [PORT_W-1:0]              second_port_lines_out,
  output logic      [PORT_W-1:0]              second_port_lines_oe_n
);

  // the chip select pin doubles as the programming pin; here only its select role
  logic chip_sel_low_n;
  assign chip_sel_low_n = program_or_chip_sel_n;

  // ------------------------------------------------------------------
  // address latch
  // ------------------------------------------------------------------
  logic [mrp_pkg::ADDR_LOW_W-1:0]  addr_low_reg;
  logic [mrp_pkg::ADDR_HIGH_W-1:0] addr_high_reg;
  logic                            io_sel_reg;
  logic                            csl_n_reg;
  logic                            csh_reg;

  // transparent while the strobe is high; the last sample before the
  // fall is what stays, which is the capture on the falling edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      addr_low_reg <= mrp_pkg::RST_ADDR_LOW;
    end else if (ale) begin
      addr_low_reg <= muxed_addr_data_in; // RL1 RL2
    end else begin
      addr_low_reg <= addr_low_reg; // RL16
    end
  end

  // upper rom bits ride the same strobe but never reach the port decode
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      addr_high_reg <= mrp_pkg::RST_ADDR_HIGH;
    end else if (ale) begin
      addr_high_reg <= upper_rom_addr; // RL1
    end else begin
      addr_high_reg <= addr_high_reg; // RL16
    end
  end

  // space select, consulted only by the read path
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      io_sel_reg <= mrp_pkg::RST_IO_SEL;
    end else if (ale) begin
      io_sel_reg <= io_mem_sel; // RL1
    end else begin
      io_sel_reg <= io_sel_reg; // RL16
    end
  end

  // selects are kept as seen, so a later deselect cannot cut an access short
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      csl_n_reg <= mrp_pkg::RST_CSL_N;
    end else if (ale) begin
      csl_n_reg <= chip_sel_low_n; // RL1
    end else begin
      csl_n_reg <= csl_n_reg; // RL16
    end
  end

  // second select, active high, kept the same way
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      csh_reg <= mrp_pkg::RST_CSH;
    end else if (ale) begin
      csh_reg <= chip_sel_high; // RL1
    end else begin
      csh_reg <= csh_reg; // RL16
    end
  end

  // ------------------------------------------------------------------
  // selection decode
  // ------------------------------------------------------------------
  wire       sel_latched_ok;
  wire       sel_live_ok;
  wire [1:0] port_target;
  wire       target_second;
  wire       target_is_dir;

  // both selects must have been active when latched
  assign sel_latched_ok = ~csl_n_reg & csh_reg; // RL6
  assign sel_live_ok    = ~chip_sel_low_n & chip_sel_high; // RL11

  // the upper address bits are deliberately absent from this decode
  assign port_target   = addr_low_reg[mrp_pkg::SEL_DIR_BIT:mrp_pkg::SEL_PORT_BIT]; // RL5
  assign target_second = port_target[mrp_pkg::SEL_PORT_BIT]; // RL3 RL13
  assign target_is_dir = port_target[mrp_pkg::SEL_DIR_BIT]; // RL13

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------
  wire                            rd_mem;
  wire                            rd_port;
  wire                            rd_any;
  wire [PORT_W-1:0]               first_read_val;
  wire [PORT_W-1:0]               second_read_val;
  wire [PORT_W-1:0]               port_read_val;
  mrp_pkg::mrp_src_t              src_next;
  logic [mrp_pkg::ADDR_LOW_W-1:0] bus_data_next;

  // a read strobe with the space select high behaves as a port read
  assign rd_any  = ~read_strobe_n | ~port_read_strobe_n; // RL4 RL9
  assign rd_port = ~port_read_strobe_n | (~read_strobe_n & io_sel_reg); // RL8
  assign rd_mem  = ~read_strobe_n & ~io_sel_reg & port_read_strobe_n; // RL8

  // direction registers cannot be read, so bit one is ignored here
  assign port_read_val = target_second ? second_read_val : first_read_val; // RL3

  wire rd_granted;
  wire pick_port;
  wire pick_rom;
  wire bus_release;

  // nothing is driven unless the selects were active when latched
  assign rd_granted = sel_latched_ok & rd_any; // RL4 RL6 RL7
  assign pick_port  = rd_granted & rd_port; // RL4 RL8
  assign pick_rom   = rd_granted & rd_mem; // RL8

  // pick the driver of the shared bus; the port wins when both strobes are low
  assign src_next    = pick_port ? mrp_pkg::MRP_SRC_PORT :
                       pick_rom  ? mrp_pkg::MRP_SRC_ROM  :
                                   mrp_pkg::MRP_SRC_NONE;
  assign bus_release = (src_next == mrp_pkg::MRP_SRC_NONE); // RL9

  // data for the chosen source
  always_comb begin
    case (src_next)
      mrp_pkg::MRP_SRC_ROM:  bus_data_next = rom_data; // RL8
      mrp_pkg::MRP_SRC_PORT: bus_data_next = mrp_pkg::ADDR_LOW_W'(port_read_val); // RL8
      mrp_pkg::MRP_SRC_NONE: bus_data_next = mrp_pkg::RST_BUS_DATA;
      default:               bus_data_next = mrp_pkg::RST_BUS_DATA;
    endcase
  end

  logic [mrp_pkg::ADDR_LOW_W-1:0] bus_out_reg;
  logic                           bus_oe_n_reg;

  // registered so every pin comes from a flop; costs one cycle of latency
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_out_reg <= mrp_pkg::RST_BUS_DATA;
    end else begin
      bus_out_reg <= bus_data_next; // RL8
    end
  end

  // the enable moves in the same cycle, so data and drive appear together
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_oe_n_reg <= 1'h1;
    end else begin
      bus_oe_n_reg <= bus_release; // RL4 RL7 RL9
    end
  end

  assign muxed_addr_data_out  = bus_out_reg;
  assign muxed_addr_data_oe_n = bus_oe_n_reg;

  // ------------------------------------------------------------------
  // write path
  // ------------------------------------------------------------------
  wire  wr_active;
  wire  wr_commit;
  logic wr_active_reg;

  // space select plays no part in a port write
  assign wr_active = ~port_write_strobe_n & sel_latched_ok; // RL10
  assign wr_commit = wr_active_reg & port_write_strobe_n; // RL15

  // remembers that a write is in flight so its release can be seen
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_active_reg <= 1'b0;
    end else begin
      wr_active_reg <= wr_active;
    end
  end

  wire first_take;
  wire second_take;

  // route the write to the port that the latched bits pick
  assign first_take  = wr_active & ~target_second; // RL10 RL13
  assign second_take = wr_active & target_second; // RL10 RL13

  // a commit also clears any stale pending value in the other port
  mrp_io_port #(
    .W (PORT_W)
  ) u_first_port (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .wr_take   (first_take),
    .wr_commit (wr_commit),
    .wr_is_dir (target_is_dir),
    .wr_data   (PORT_W'(muxed_addr_data_in)),
    .pins_in   (first_port_lines_in),
    .pins_out  (first_port_lines_out),
    .pins_oe_n (first_port_lines_oe_n),
    .read_val  (first_read_val)
  );

  mrp_io_port #(
    .W (PORT_W)
  ) u_second_port (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .wr_take   (second_take),
    .wr_commit (wr_commit),
    .wr_is_dir (target_is_dir),
    .wr_data   (PORT_W'(muxed_addr_data_in)),
    .pins_in   (second_port_lines_in),
    .pins_out  (second_port_lines_out),
    .pins_oe_n (second_port_lines_oe_n),
    .read_val  (second_read_val)
  );

  // ------------------------------------------------------------------
  // wait output
  // ------------------------------------------------------------------
  logic cpu_clk_prev_reg;
  logic wait_low_reg;
  wire  cpu_clk_rise;
  wire  wait_set;
  wire  wait_low_next;

  // the processor clock is an ordinary sampled input, not a second domain;
  // limitation: each of its phases must last a full cycle to be seen
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cpu_clk_prev_reg <= 1'b0;
    end else begin
      cpu_clk_prev_reg <= cpu_clk;
    end
  end

  assign cpu_clk_rise = cpu_clk & ~cpu_clk_prev_reg;
  assign wait_set     = sel_live_ok & ale; // RL11

  // set wins over the release, so a pull in the rising-edge cycle holds
  assign wait_low_next = wait_set | (wait_low_reg & ~cpu_clk_rise); // RL11 RL12

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wait_low_reg <= 1'b0;
    end else begin
      wait_low_reg <= wait_low_next; // RL7 RL12
    end
  end

  // the line is only ever driven low, otherwise released
  assign wait_out  = 1'b0;
  assign wait_oe_n = ~wait_low_reg;

  // rom address straight from the latch flops
  assign rom_addr = {addr_high_reg, addr_low_reg}; // RL5

endmodule : mrp_host_port

// ==== dv/mrp_host_port_properties.sv ====
module mrp_host_port_chk #(
  parameter int PORT_W = 8
) (
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic              ale,
  input wire logic [7:0]        muxed_addr_data_in,
  input wire logic [7:0]        muxed_addr_data_out,
  input wire logic              muxed_addr_data_oe_n,
  input wire logic [2:0]        upper_rom_addr,
  input wire logic              io_mem_sel,
  input wire logic              program_or_chip_sel_n,
  input wire logic              chip_sel_high,
  input wire logic              read_strobe_n,
  input wire logic              port_read_strobe_n,
  input wire logic              port_write_strobe_n,
  input wire logic              cpu_clk,
  input wire logic              wait_oe_n,
  input wire logic [10:0]       rom_addr,
  input wire logic [7:0]        rom_data,
  input wire logic [PORT_W-1:0] first_port_lines_out,
  input wire logic [PORT_W-1:0] second_port_lines_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic cs_reg;
  logic io_reg;

  // own copy of the latched selects, so checks do not trust the design's latch
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cs_reg <= 1'b0;
      io_reg <= 1'b0;
    end else if (ale) begin
      cs_reg <= !program_or_chip_sel_n && chip_sel_high;
      io_reg <= io_mem_sel;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // address path, drive, wait and port pin relations
  latch_addr_a: assert property (ale
    |=> rom_addr == $past({upper_rom_addr, muxed_addr_data_in}))
    else $error("latched address wrong");
  latch_hold_a: assert property (!ale |=> $stable(rom_addr))
    else $error("latched address moved");
  read_drive_a: assert property ((cs_reg && !ale && !(read_strobe_n && port_read_strobe_n))
    |=> !muxed_addr_data_oe_n) else $error("read not driven");
  bus_release_a: assert property ((read_strobe_n && port_read_strobe_n)
    |=> muxed_addr_data_oe_n) else $error("bus driven without strobe");
  no_sel_drive_a: assert property ((!cs_reg && !ale) |=> muxed_addr_data_oe_n)
    else $error("bus driven while deselected");
  rom_read_a: assert property ((cs_reg && !ale && !read_strobe_n
    && port_read_strobe_n && !io_reg) |=> muxed_addr_data_out == $past(rom_data))
    else $error("rom data wrong");
  wait_set_a: assert property ((ale && !program_or_chip_sel_n && chip_sel_high)
    |=> !wait_oe_n) else $error("wait not pulled");
  wait_hold_a: assert property ((!wait_oe_n && !$rose(cpu_clk)) |=> !wait_oe_n)
    else $error("wait released early");
  wait_release_a: assert property ((!wait_oe_n && $rose(cpu_clk) && !ale) |=> wait_oe_n)
    else $error("wait not released");
  pins_glitch_a: assert property (!port_write_strobe_n
    |=> $stable(first_port_lines_out) && $stable(second_port_lines_out)) else $error("pins moved");

  cover property (ale && !program_or_chip_sel_n && chip_sel_high);
  cover property (!muxed_addr_data_oe_n && io_reg);
  cover property (!port_write_strobe_n && cs_reg);
endmodule : mrp_host_port_chk

bind mrp_host_port mrp_host_port_chk #(.PORT_W(PORT_W)) chk_i (.clk_sys, .rst, .ale,
  .muxed_addr_data_in, .muxed_addr_data_out, .muxed_addr_data_oe_n, .upper_rom_addr,
  .io_mem_sel, .program_or_chip_sel_n, .chip_sel_high, .read_strobe_n, .port_read_strobe_n,
  .port_write_strobe_n, .cpu_clk, .wait_oe_n, .rom_addr, .rom_data, .first_port_lines_out,
  .second_port_lines_out);

// ==== dv/mrp_far_model.sv ====
module mrp_far_model (
  input  wire logic [10:0] rom_addr,
  output logic      [7:0]  rom_data,
  input  wire logic [7:0]  first_port_lines_out,
  input  wire logic [7:0]  first_port_lines_oe_n,
  output logic      [7:0]  first_port_lines_in,
  input  wire logic [7:0]  second_port_lines_out,
  input  wire logic [7:0]  second_port_lines_oe_n,
  output logic      [7:0]  second_port_lines_in,
  input  wire logic [7:0]  ext_a,
  input  wire logic [7:0]  ext_b
);
  timeunit 1ns;
  timeprecision 1ns;
  // rom array contents mix in the upper bits so they are seen on rom reads
  assign rom_data = rom_addr[7:0] ^ {rom_addr[10:8], 5'h0B};
  // pin level: the block where it drives, the outside driver elsewhere
  assign first_port_lines_in  = (~first_port_lines_oe_n & first_port_lines_out)
                              | (first_port_lines_oe_n & ext_a);
  assign second_port_lines_in = (~second_port_lines_oe_n & second_port_lines_out)
                              | (second_port_lines_oe_n & ext_b);
endmodule : mrp_far_model

// ==== dv/tb_muxed_bus_rom_io_host_port.sv ====
module tb_muxed_bus_rom_io_host_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst = 1'b1, ale = 1'b0, io_mem_sel = 1'b0, cpu_clk = 1'b0;
  logic program_or_chip_sel_n = 1'b1, chip_sel_high = 1'b0, muxed_addr_data_oe_n;
  logic read_strobe_n = 1'b1, port_read_strobe_n = 1'b1, port_write_strobe_n = 1'b1;
  logic wait_out, wait_oe_n;
  logic [2:0]  upper_rom_addr = 3'h0;
  logic [10:0] rom_addr, m_a;
  logic [7:0]  muxed_addr_data_in = 8'h00, muxed_addr_data_out, rom_data, ext_a = 8'h00;
  logic [7:0]  ext_b = 8'h00, first_port_lines_in, first_port_lines_out, first_port_lines_oe_n;
  logic [7:0]  second_port_lines_in, second_port_lines_out, second_port_lines_oe_n;
  logic [7:0]  m_dat [2], m_dir [2];
  logic        m_cs, m_io;
  logic [31:0] seed = 32'h891FF89E;
  int          errors = 0, tests_run = 0, cycles = 0;

  mrp_host_port uut (.clk_sys, .rst, .ale, .muxed_addr_data_in, .muxed_addr_data_out,
    .muxed_addr_data_oe_n, .upper_rom_addr, .io_mem_sel, .program_or_chip_sel_n,
    .chip_sel_high, .read_strobe_n, .port_read_strobe_n, .port_write_strobe_n, .cpu_clk,
    .wait_out, .wait_oe_n, .rom_addr, .rom_data, .first_port_lines_in, .first_port_lines_out,
    .first_port_lines_oe_n, .second_port_lines_in, .second_port_lines_out,
    .second_port_lines_oe_n);
  mrp_far_model far (.rom_addr, .rom_data, .first_port_lines_out, .first_port_lines_oe_n,
    .first_port_lines_in, .second_port_lines_out, .second_port_lines_oe_n,
    .second_port_lines_in, .ext_a, .ext_b);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] rom_val(input logic [10:0] a);
    return a[7:0] ^ {a[10:8], 5'h0B};
  endfunction : rom_val
  function automatic logic [7:0] pval(input int p);
    return (m_dir[p] & m_dat[p]) | (~m_dir[p] & (p == 1 ? ext_b : ext_a));
  endfunction : pval

  task automatic cyc;
    @(posedge clk_sys);
    #10;
  endtask : cyc
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_pins;
    chk(first_port_lines_out, m_dat[0]);
    chk(first_port_lines_oe_n, 8'(~m_dir[0]));
    chk(second_port_lines_out, m_dat[1]);
    chk(second_port_lines_oe_n, 8'(~m_dir[1]));
  endtask : chk_pins
  task automatic do_reset(input int n);
    rst = 1'b1;
    repeat (n) cyc;
    rst = 1'b0;
    m_dat = '{8'h00, 8'h00};
    m_dir = '{8'h00, 8'h00};
    m_cs = 1'b0;
    chk_pins;
    chk(muxed_addr_data_oe_n, 1'b1);
    chk(wait_oe_n, 1'b1);
  endtask : do_reset
  // address phase; live inputs are scrambled after the strobe falls
  task automatic latch(input logic [10:0] a, input logic io, input logic cl, input logic ch);
    ale = 1'b1;
    {upper_rom_addr, muxed_addr_data_in} = a;
    {io_mem_sel, program_or_chip_sel_n, chip_sel_high} = {io, cl, ch};
    cyc;
    {m_a, m_io, m_cs} = {a, io, !cl && ch};
    chk(rom_addr, a);
    chk(wait_oe_n, !m_cs);
    chk(wait_out, 1'h0);
    ale = 1'b0;
    {upper_rom_addr, muxed_addr_data_in} = ~a;
    {io_mem_sel, program_or_chip_sel_n, chip_sel_high} = {!io, !cl, !ch};
    cyc;
    chk(wait_oe_n, !m_cs);
    cpu_clk = 1'b1;
    cyc;
    chk(wait_oe_n, 1'b1);
    chk(rom_addr, a);
    cpu_clk = 1'b0;
  endtask : latch
  task automatic rd(input logic pr);
    logic [7:0] e;
    e = (pr || m_io) ? pval(int'(m_a[0])) : rom_val(m_a);
    {port_read_strobe_n, read_strobe_n} = {!pr, pr};
    cyc;
    chk(muxed_addr_data_oe_n, !m_cs);
    if (m_cs)
      chk(muxed_addr_data_out, e);
    {port_read_strobe_n, read_strobe_n} = 2'h3;
    cyc;
    chk(muxed_addr_data_oe_n, 1'b1);
  endtask : rd
  task automatic wr(input logic [7:0] d);
    muxed_addr_data_in = d;
    port_write_strobe_n = 1'b0;
    cyc;
    chk_pins;
    port_write_strobe_n = 1'b1;
    muxed_addr_data_in = ~d;
    cyc;
    if (m_cs && m_a[1])
      m_dir[m_a[0]] = d;
    else if (m_cs)
      m_dat[m_a[0]] = d;
    chk_pins;
  endtask : wr
  task automatic complete_run;
    if (errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  // free-running 10 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      complete_run;
    end
  end

  // every target code once, then random mixed traffic with a reset in the middle
  initial begin
    do_reset(10);
    for (int c = 0; c < 4; c++) begin
      seed = lfsr(seed);
      latch({3'h5, 6'h15, c[1:0]}, 1'b0, 1'b0, 1'b1);
      wr(seed[7:0]);
      rd(1'b1);
    end
    for (int i = 0; i < 60; i++) begin
      if (i == 30)
        do_reset(2);
      seed = lfsr(seed);
      {ext_b, ext_a} = seed[15:0];
      latch(seed[26:16], seed[27], seed[28] & seed[29], !(seed[30] & seed[31]));
      seed = lfsr(seed);
      if (seed[1:0] == 2'h0)
        wr(seed[15:8]);
      else
        rd(seed[0]);
    end
    complete_run;
  end
endmodule : tb_muxed_bus_rom_io_host_port
